/* common/bbsp_pkg.sv */
// package: timing constants and carrier types for the battery-backed sram host port
package bbsp_pkg;

   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_PS = 5000;

   // printed figures in ns, faster grade
   localparam int ADDR_ACCESS_TIME_NS = 70;
   localparam int SELECT_ACCESS_TIME_NS = 70;
   localparam int DRIVE_ACCESS_TIME_NS = 40;
   localparam int ADDR_CHANGE_HOLD_TIME_NS = 10;
   localparam int STROBE_LOW_TO_FLOAT_NS = 25;
   localparam int WRITE_DATA_SETUP_NS = 30;
   localparam int WRITE_DATA_HOLD_NS = 5;
   localparam int SELECT_RELEASE_RECOVERY_NS = 10;
   localparam int STROBE_RELEASE_RECOVERY_NS = 5;
   localparam int STROBE_PULSE_NS = 50;
   localparam int SELECT_PULSE_NS = 55;
   localparam int CYCLE_TIME_NS = 70;
   localparam int ADDR_TO_STROBE_HIGH_NS = 60;
   localparam int ADDR_SETUP_NS = 0;

   // least times round up to whole cycles, at least one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // read sample point: latest of the three access times, data floats during write strobe
   localparam int READ_CYC = cyc_up(ADDR_ACCESS_TIME_NS > DRIVE_ACCESS_TIME_NS ?
      (ADDR_ACCESS_TIME_NS > SELECT_ACCESS_TIME_NS ? ADDR_ACCESS_TIME_NS : SELECT_ACCESS_TIME_NS)
      : DRIVE_ACCESS_TIME_NS);
   localparam int FLOAT_CYC = cyc_up(STROBE_LOW_TO_FLOAT_NS);
   localparam int WSTROBE_CYC_RAW = cyc_up(STROBE_PULSE_NS) > cyc_up(SELECT_PULSE_NS) ?
      cyc_up(STROBE_PULSE_NS) : cyc_up(SELECT_PULSE_NS);
   localparam int ADDR_WH_CYC = cyc_up(ADDR_TO_STROBE_HIGH_NS);
   localparam int WSTROBE_CYC0 = WSTROBE_CYC_RAW > ADDR_WH_CYC ? WSTROBE_CYC_RAW : ADDR_WH_CYC;
   localparam int WSTROBE_CYC = WSTROBE_CYC0 > cyc_up(WRITE_DATA_SETUP_NS) ?
      WSTROBE_CYC0 : cyc_up(WRITE_DATA_SETUP_NS);
   localparam int HOLD_CYC = cyc_up(SELECT_RELEASE_RECOVERY_NS) > cyc_up(WRITE_DATA_HOLD_NS) ?
      cyc_up(SELECT_RELEASE_RECOVERY_NS) : cyc_up(WRITE_DATA_HOLD_NS);
   localparam int CYCLE_CYC = cyc_up(CYCLE_TIME_NS);
   localparam int READ_HOLD_CYC = cyc_up(ADDR_CHANGE_HOLD_TIME_NS);
   localparam int CNT_W = 8;
   localparam int RECOVERY_CYC_DEFAULT = 40000;
   localparam int REC_W = 24;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bbsp_req_type;

   typedef struct packed {
      logic select_n;
      logic drive_n;
      logic strobe_n;
      logic [ADDR_W-1:0] byte_addr;
   } bbsp_pins_type;

endpackage

/* rtl/bbsp_host.sv */
// host controller that drives the battery-backed sram port through its pins
// Behaviour
// - host holds address stable whole write, set up by falling edge.
// - host keeps strobe/select high 10 ns or 5 ns, address unchanged.
// - host presents write data 30 ns before end, holds 5 ns after.
// - host keeps output enable high during writes.
// - strobe low 50 ns, select write 55 ns, cycle 70 ns minimum.
// - address valid 60 ns before terminating strobe rise.
`timescale 1ns/1ps
module bbsp_host #(
   parameter int RECOVERY_CYC = bbsp_pkg::RECOVERY_CYC_DEFAULT
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // user request side
   input wire logic req_valid,
   output logic req_ready,
   input wire bbsp_pkg::bbsp_req_type req,
   output logic rsp_valid,
   output logic [bbsp_pkg::DATA_W-1:0] rsp_rdata,
   // supply status
   input wire logic supply_fail,
   output logic port_ready,
   // device pins
   output bbsp_pkg::bbsp_pins_type pins,
   input wire logic [bbsp_pkg::DATA_W-1:0] data_bus_in,
   output logic [bbsp_pkg::DATA_W-1:0] data_bus_out,
   output logic data_bus_oe_n
);
   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_RGAP, ST_WRITE, ST_WHOLD, ST_WAIT}
      bbsp_state_type;

   bbsp_state_type state_q;
   logic [bbsp_pkg::CNT_W-1:0] cnt_q;
   logic [bbsp_pkg::CNT_W-1:0] cyc_q;
   logic [bbsp_pkg::REC_W-1:0] rec_q;
   logic [bbsp_pkg::DATA_W-1:0] din_s;
   logic fail_s;
   logic is_write;
   logic [bbsp_pkg::DATA_W:0] sync_out;
   logic [bbsp_pkg::ADDR_W-1:0] addr_q;
   logic select_n_q;
   logic strobe_n_q;
   logic drive_n_q;

   // data and supply status come from outside the clock domain
   bbsp_sync #(.WIDTH(bbsp_pkg::DATA_W + 1)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .async_in({supply_fail, data_bus_in}),
      .sync_out(sync_out)
   );
   assign din_s = sync_out[bbsp_pkg::DATA_W-1:0];
   assign fail_s = sync_out[bbsp_pkg::DATA_W];

   // recovery delay after supply returns before accesses resume
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rec_q <= bbsp_pkg::REC_W'(RECOVERY_CYC);
      else if (fail_s)
         rec_q <= bbsp_pkg::REC_W'(RECOVERY_CYC);
      else if (rec_q != '0)
         rec_q <= rec_q - 1'b1;
   end

   assign port_ready = (rec_q == '0) && !fail_s;
   assign req_ready = (state_q == ST_IDLE) && port_ready;
   assign is_write = state_q == ST_WRITE || state_q == ST_WHOLD;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         cyc_q <= '0;
      end
      else
      begin
         if (cyc_q != '0)
            cyc_q <= cyc_q - 1'b1;
         case (state_q)
            ST_IDLE:
            begin
               if (req_valid && req_ready)
               begin
                  state_q <= req.write ? ST_WRITE : ST_READ;
                  // one cycle of margin past the access time, two for the input synchroniser
                  cnt_q <= req.write ? bbsp_pkg::CNT_W'(bbsp_pkg::WSTROBE_CYC)
                     : bbsp_pkg::CNT_W'(bbsp_pkg::READ_CYC + 3);
                  cyc_q <= bbsp_pkg::CNT_W'(bbsp_pkg::CYCLE_CYC);
               end
            end
            ST_READ:
            begin
               if (cnt_q == 1)
               begin
                  state_q <= ST_RGAP;
                  cnt_q <= bbsp_pkg::CNT_W'(bbsp_pkg::READ_HOLD_CYC);
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            ST_WRITE:
            begin
               // a supply failure ends the write early; only this byte is at risk
               if (cnt_q == 1 || fail_s)
               begin
                  state_q <= ST_WHOLD;
                  cnt_q <= bbsp_pkg::CNT_W'(bbsp_pkg::HOLD_CYC);
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            ST_RGAP, ST_WHOLD:
            begin
               if (cnt_q == 1)
                  state_q <= ST_WAIT;
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            ST_WAIT:
            begin
               if (cyc_q <= 1)
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // address and write data latched at request, held until the next one
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         addr_q <= '0;
         data_bus_out <= '0;
      end
      else if (state_q == ST_IDLE && req_valid && req_ready)
      begin
         addr_q <= req.addr;
         data_bus_out <= req.wdata;
      end
   end

   // control pins from flops; select and strobe fall together so data stays floated
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         select_n_q <= 1'b1;
         strobe_n_q <= 1'b1;
         drive_n_q <= 1'b1;
         data_bus_oe_n <= 1'b1;
      end
      else
      begin
         select_n_q <= !(state_q == ST_IDLE && req_valid && req_ready
            || state_q == ST_READ && cnt_q != 1
            || state_q == ST_WRITE && cnt_q != 1 && !fail_s);
         strobe_n_q <= !(state_q == ST_IDLE && req_valid && req_ready && req.write
            || state_q == ST_WRITE && cnt_q != 1 && !fail_s);
         drive_n_q <= !(state_q == ST_IDLE && req_valid && req_ready && !req.write
            || state_q == ST_READ && cnt_q != 1);
         // keep driving through the data hold after the strobe rises
         data_bus_oe_n <= !(state_q == ST_IDLE && req_valid && req_ready && req.write
            || state_q == ST_WRITE || state_q == ST_WHOLD && cnt_q != 1);
      end
   end

   // one driver for the whole pin group; every field comes straight from a flop
   assign pins = '{select_n: select_n_q, drive_n: drive_n_q, strobe_n: strobe_n_q,
      byte_addr: addr_q};

   // sample at the last read cycle, after every access time has passed
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else
      begin
         rsp_valid <= state_q == ST_READ && cnt_q == 1 && !is_write;
         if (state_q == ST_READ && cnt_q == 1)
            rsp_rdata <= din_s;
      end
   end
endmodule

/* rtl/bbsp_sync.sv */
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module bbsp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

/* sim/bbsp_host_sva.sv */
// checker for the sram host port, bound to the host controller
`timescale 1ns/1ps
module bbsp_host_sva #(
   parameter int RECOVERY_CYC = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // user side
   input wire logic req_valid,
   input wire logic req_ready,
   input wire bbsp_pkg::bbsp_req_type req,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_rdata,
   // supply
   input wire logic supply_fail,
   input wire logic port_ready,
   // pins
   input wire bbsp_pkg::bbsp_pins_type pins,
   input wire logic [7:0] data_bus_in,
   input wire logic [7:0] data_bus_out,
   input wire logic data_bus_oe_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence low12; !pins.strobe_n [*8] ##1 !pins.strobe_n [*4]; endsequence
   sequence rd_walk;
      !pins.drive_n [*8] ##1 !pins.drive_n [*8] ##1 !pins.drive_n
         ##1 ($rose(pins.drive_n) && rsp_valid);
   endsequence
   a_write_no_drive: assert property (!pins.strobe_n |-> pins.drive_n)
      else $error("drive during write");
   a_edges_together: assert property ($fell(pins.strobe_n) |-> $fell(pins.select_n))
      else $error("strobe without select");
   // a supply failure may cut a write short, so write strobe width and data hold are only judged without one
   a_strobe_width: assert property (disable iff (!rstn || supply_fail)
      $fell(pins.strobe_n) |-> low12 ##1 pins.strobe_n)
      else $error("strobe width");
   a_data_held: assert property (disable iff (!rstn || supply_fail)
      !pins.strobe_n |=> !data_bus_oe_n && $stable(data_bus_out))
      else $error("write data moved");
   a_addr_stable: assert property ($past(!pins.select_n) |-> $stable(pins.byte_addr))
      else $error("address moved");
   a_select_gap: assert property ($rose(pins.select_n) |-> pins.select_n [*2])
      else $error("select gap short");
   a_read_time: assert property ($fell(pins.drive_n) |-> rd_walk)
      else $error("read timing");
   a_fail_block: assert property (supply_fail [*4] |-> !req_ready && pins.strobe_n)
      else $error("not blocked in fail");
   a_recovery_hold: assert property (supply_fail [*4] ##1 !supply_fail |=> !port_ready [*8])
      else $error("recovery too short");
endmodule
bind bbsp_host bbsp_host_sva #(.RECOVERY_CYC(RECOVERY_CYC)) bbsp_host_sva_i (.clock(clock),
   .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
   .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .supply_fail(supply_fail),
   .port_ready(port_ready), .pins(pins), .data_bus_in(data_bus_in),
   .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n));

/* sim/bbsp_sram_model.sv */
// pin-level model of the battery-backed byte-wide sram
`timescale 1ns/1ps
module bbsp_sram_model #(
   // write protection lasts this long after supply returns
   parameter real RECOVERY_NS = 50.0
) (
   // device pins
   input wire bbsp_pkg::bbsp_pins_type pins,
   input wire logic supply_fail,
   // host side of the data wire
   input wire logic [7:0] host_dq,
   input wire logic host_oe_n,
   // resolved data wire
   output logic [7:0] dq
);
   logic [7:0] mem [logic [18:0]];
   logic [7:0] last = 8'h00;
   realtime t_acc = 0.0;
   logic powered = 1'b1;
   wire logic wr_on = !pins.select_n && !pins.strobe_n && !supply_fail
      && powered;
   wire logic rd_on = !pins.select_n && !pins.drive_n && pins.strobe_n
      && !supply_fail && powered;
   // an early access after supply returns is ignored, so it reads back as garbage
   always @(supply_fail)
      if (supply_fail)
         powered = 1'b0;
      else
         powered <= #(RECOVERY_NS) 1'b1;
   always @(pins.byte_addr or negedge pins.select_n)
      t_acc = $realtime;
   always @(negedge wr_on)
      if (!supply_fail)
         mem[pins.byte_addr] = dq;
   // a released wire toggles so a stale byte cannot pass for a read
   always #1
   begin
      if (!host_oe_n)
         dq = host_dq;
      else if (rd_on && $realtime - t_acc >= 70.0)
         dq = mem.exists(pins.byte_addr) ? mem[pins.byte_addr] : 8'h00;
      else
         dq = ~last;
      last = dq;
   end
endmodule

/* sim/tb_top.sv */
// self-checking bench for the sram host port
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'h0;
   logic rstn = 1'h0;
   logic req_valid = 1'h0;
   logic supply_fail = 1'h0;
   bbsp_pkg::bbsp_req_type req = '0;
   logic req_ready, rsp_valid, port_ready, data_bus_oe_n;
   logic [7:0] rsp_rdata, data_bus_in, data_bus_out, rd;
   bbsp_pkg::bbsp_pins_type pins;
   int err_count = 0;
   int cmp_count = 0;
   bbsp_pkg::bbsp_req_type rows [6] = '{'{1'h1, 19'h00000, 8'hA5}, '{1'h1, 19'h7FFFF, 8'h5A},
      '{1'h1, 19'h00001, 8'h3C}, '{1'h0, 19'h00000, 8'hA5}, '{1'h0, 19'h7FFFF, 8'h5A},
      '{1'h0, 19'h00001, 8'h3C}};
   always #2.5 clock = ~clock;
   bbsp_host #(.RECOVERY_CYC(20)) bbsp_host_i (.clock(clock), .rstn(rstn),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .supply_fail(supply_fail), .port_ready(port_ready),
      .pins(pins), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
      .data_bus_oe_n(data_bus_oe_n));
   bbsp_sram_model bbsp_sram_model_i (.pins(pins), .supply_fail(supply_fail),
      .host_dq(data_bus_out), .host_oe_n(data_bus_oe_n), .dq(data_bus_in));
   task automatic end_of_test();
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check1(input string what, input logic exp, input logic got);
      check8(what, {7'h00, exp}, {7'h00, got});
   endtask
   // one request, waiting for the read answer; a hang ends the run
   task automatic access(input bbsp_pkg::bbsp_req_type r, output logic [7:0] data);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      req = r;
      req_valid = 1'h1;
      @(negedge clock);
      req_valid = 1'h0;
      while (!r.write && rsp_valid !== 1'b1 && n < 240)
      begin
         @(negedge clock);
         n++;
      end
      data = rsp_rdata;
      if (n >= 200)
      begin
         check1("handshake", 1'h1, 1'h0);
         end_of_test();
      end
   endtask
   initial
   begin
      repeat (4) @(negedge clock);
      check1("select_n", 1'h1, pins.select_n);
      check1("req_ready", 1'h0, req_ready);
      rstn = 1'h1;
      repeat (18) @(negedge clock);
      check1("req_ready", 1'h0, req_ready);
      check1("port_ready", 1'h0, port_ready);
      $display("reset test done");
      foreach (rows[i])
      begin
         access(rows[i], rd);
         if (!rows[i].write)
            check8("read byte", rows[i].wdata, rd);
      end
      $display("row test done");
      access('{1'h1, 19'h00002, 8'h77}, rd);
      repeat (2) @(negedge clock);
      supply_fail = 1'h1;
      req = '{1'h1, 19'h00001, 8'hFF};
      req_valid = 1'h1;
      repeat (6) @(negedge clock);
      check1("strobe_n", 1'h1, pins.strobe_n);
      check1("select_n", 1'h1, pins.select_n);
      check1("req_ready", 1'h0, req_ready);
      req_valid = 1'h0;
      supply_fail = 1'h0;
      repeat (10) @(negedge clock);
      check1("req_ready", 1'h0, req_ready);
      access('{1'h0, 19'h00001, 8'h00}, rd);
      check8("kept byte", 8'h3C, rd);
      access('{1'h0, 19'h7FFFF, 8'h00}, rd);
      check8("kept byte", 8'h5A, rd);
      check1("port_ready", 1'h1, port_ready);
      $display("supply fail test done");
      end_of_test();
   end
endmodule
